// ### design/sfc_flash_front.sv
// sfc_flash_front: serial flash command front end, status, extended address and reads
// Functional notes
// - status read opcodes return status byte 0, 1 or 2 respectively.
// - status reads are served even while an internal cycle runs.
// - status byte repeats for as long as chip select stays low.
// - status writes need the write-enable latch set by an earlier command.
// - status bits 19, 18, 15, 10, 8, 1 and 0 are never written.
// - status write discarded unless chip select rises on a byte boundary.
// - chip select rise starts timed write; busy flag set, then latch cleared.
// - status write updates block protect, top/bottom and protect bits.
// - hardware protection (protect bit plus write-protect pin low) blocks status writes.
// - opcode 01h writes byte zero after 8 bits, bytes zero and one after 16.
// - extended register read shifts out on falling edges, MSB first.
// - in four-byte mode the upper address bit is ignored.
// - extended register write works whatever the write-enable latch holds.
// - extended register clears at power-up and on any reset.
// - plain read samples address on rising, drives data on falling edges.
// - reads start anywhere, auto-increment and stream until chip select rises.
// - reads during an internal cycle are rejected, the cycle is untouched.
// - fast read waits one dummy byte before data.
// - dual output read returns two bits per clock.
// - quad output read returns four bits per clock.
// - dual I/O read takes address and mode two bits per clock.
// - mode bits 5..4 = 10 skip the next opcode; reset clears this.
// - dual output: odd bits on line one, even on line zero, top first.
// - quad output: bits 7..4 then 3..0 on lines three to zero.
// - dual input: odd address and mode bits on line one, even on zero.
// - a bare write-enable opcode frame sets the write-enable latch.
`timescale 1ns/1ps
`default_nettype none
module sfc_flash_front
  import sfc_pkg::*;
#(
  parameter int TW_CYCLES = (sfc_pkg::TW_NS + sfc_pkg::CLK_NS - 1) / sfc_pkg::CLK_NS,
  parameter int BUF_DEPTH = 2,
  parameter int BUF_W     = 8
) (
  input  wire logic               clock,                // system clock
  input  wire logic               rst,                  // async reset
  input  wire sfc_pkg::sfc_pins_s pins,                 // raw link pins
  output logic [3:0]              io_out,               // data line values
  output logic [3:0]              io_oe_n,              // low while driving
  input  wire logic               addr_four_byte_state, // four-byte address mode
  input  wire logic               array_busy,           // program or erase running
  output logic                    mem_req_valid,        // fetch request
  input  wire logic               mem_req_ready,        // fetch accepted
  output logic [31:0]             mem_req_addr,         // fetch address
  input  wire logic               mem_rsp_valid,        // fetched byte valid
  output logic                    mem_rsp_ready,        // buffer can take a byte
  input  wire logic [BUF_W-1:0]   mem_rsp_data,         // fetched byte
  output sfc_pkg::sfc_status_s    status,               // protection and flags
  output logic                    upper_address_bit,    // extended address bit
  output logic                    continuous_mode       // opcode-less dual reads
);
  import sfc_pkg::*;
  localparam int AW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
  localparam int CW = $clog2(BUF_DEPTH + 1);
  localparam int TCW = $clog2(TW_CYCLES + 1);

  // ============================================================
  // pin synchronisers
  sfc_pins_s sync1, sync2, sync3, filt, filt_q;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sync1  <= PINS_RST;
      sync2  <= PINS_RST;
      sync3  <= PINS_RST;
      filt   <= PINS_RST;
      filt_q <= PINS_RST;
    end else begin
      sync1  <= pins;
      sync2  <= sync1;
      sync3  <= sync2;
      // a bit moves only once the second and third stage agree
      filt   <= (sync2 & sync3) | (filt & (sync2 ^ sync3));
      filt_q <= filt;
    end
  end
  logic sclk_rise, sclk_fall, cs_rise, cs_fall, sel;
  assign sclk_rise = filt.sclk && !filt_q.sclk;
  assign sclk_fall = !filt.sclk && filt_q.sclk;
  assign cs_rise   = filt.cs_n && !filt_q.cs_n;
  assign cs_fall   = !filt.cs_n && filt_q.cs_n;
  assign sel       = !filt.cs_n;

  // ============================================================
  // shared state
  sfc_state_e        state;
  logic [7:0]        cmd, in_sh, wbuf_lo, wbuf_hi, ext;
  logic [3:0]        in_cnt;
  logic [1:0]        nbytes;
  logic [2:0]        addr_cnt;
  logic              addr4, cont, rd_go, rst_armed, wip_cyc;
  logic [31:0]       addr, rd_base;
  logic [23:0]       stat;
  logic [TCW-1:0]    tw_cnt;
  logic              busy, hw_prot, dual_in, rx, in_full;
  logic [3:0]        step, in_sum;
  logic [7:0]        next_in;
  logic [31:0]       base_next;

  assign busy    = wip_cyc || array_busy;
  assign hw_prot = stat[SRP_BIT] && !filt.wp_n;
  assign dual_in = sfc_is_dio(cmd) && (state == ST_ADDR || state == ST_MODE);
  assign rx      = sclk_rise && sel;
  assign step    = dual_in ? 4'h2 : 4'h1;
  assign in_sum  = in_cnt + step;
  assign in_full = (in_sum == BYTE_BITS);
  assign next_in = dual_in ? {in_sh[5:0], filt.io[1], filt.io[0]}
                           : {in_sh[6:0], filt.io[0]};
  assign base_next = addr4 ? {addr[23:0], next_in}
                           : {7'h00, ext[0], addr[15:0], next_in};

  // ============================================================
  // frame end decoding
  logic exact0, wr_frame, is_status_write_cmd, wr_ok, sw_reset, cyc_end;
  logic [23:0] wr_val, stat_view, stat_fixed;
  assign exact0   = cs_rise && state == ST_SKIP && nbytes == '0 && in_cnt == '0;
  assign wr_frame = cs_rise && state == ST_WDATA && in_cnt == '0;
  assign is_status_write_cmd  = cmd == OP_WRSR1 || cmd == OP_WRSR2 || cmd == OP_WRSR3;
  assign wr_ok    = wr_frame && is_status_write_cmd && stat[WEL_BIT] && !hw_prot && !busy
                    && (nbytes == 2'h1 || (nbytes == 2'h2 && cmd == OP_WRSR1));
  assign sw_reset = exact0 && cmd == OP_RST && rst_armed && !busy;
  assign cyc_end  = wip_cyc && tw_cnt == '0;
  assign stat_view = {stat[23:1], busy};
  assign stat_fixed = stat & ~WR_MASK;

  always_comb begin
    case (cmd)
      OP_WRSR1: wr_val = (nbytes == 2'h2) ? {stat[23:16], wbuf_lo, wbuf_hi}
                                          : {stat[23:8], wbuf_lo};
      OP_WRSR2: wr_val = {stat[23:16], wbuf_lo, stat[7:0]};
      OP_WRSR3: wr_val = {wbuf_lo, stat[15:0]};
      default:  wr_val = stat;
    endcase
  end

  // ============================================================
  // command sequencer
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state    <= ST_OPC;
      cmd      <= 8'h00;
      in_sh    <= 8'h00;
      in_cnt   <= 4'h0;
      nbytes   <= 2'h0;
      addr_cnt <= 3'h0;
      addr4    <= 1'b0;
      addr     <= 32'h0;
      rd_base  <= 32'h0;
      rd_go    <= 1'b0;
      cont     <= 1'b0;
      wbuf_lo  <= 8'h00;
      wbuf_hi  <= 8'h00;
    end else begin
      rd_go <= 1'b0;
      if (cs_rise) begin
        state <= ST_OPC;
        if (sw_reset)
          cont <= 1'b0;
      end else if (cs_fall) begin
        in_cnt <= 4'h0;
        nbytes <= 2'h0;
        if (cont) begin
          state    <= ST_ADDR;
          addr_cnt <= addr4 ? ALEN4 : ALEN3;
        end else begin
          state <= ST_OPC;
        end
      end else if (rx) begin
        in_sh  <= next_in;
        in_cnt <= in_full ? 4'h0 : in_sum;
        if (in_full && state != ST_OPC && nbytes != NB_MAX)
          nbytes <= nbytes + 2'h1;
        if (in_full) begin
          case (state)
            ST_OPC: begin
              cmd   <= next_in;
              addr4 <= addr_four_byte_state || sfc_is_4b(next_in);
              addr_cnt <= (addr_four_byte_state || sfc_is_4b(next_in)) ? ALEN4 : ALEN3;
              if (sfc_is_read(next_in))
                state <= busy ? ST_SKIP : ST_ADDR;
              else if (next_in == OP_RDSR1 || next_in == OP_RDSR2 || next_in == OP_RDSR3
                       || next_in == OP_RDEXT)
                state <= ST_OUT;
              else if (next_in == OP_WRSR1 || next_in == OP_WRSR2 || next_in == OP_WRSR3
                       || next_in == OP_WREXT)
                state <= ST_WDATA;
              else
                state <= ST_SKIP;
            end
            ST_ADDR: begin
              addr     <= {addr[23:0], next_in};
              addr_cnt <= addr_cnt - 3'h1;
              if (addr_cnt == 3'h1) begin
                rd_go   <= 1'b1;
                rd_base <= base_next;
                if (sfc_has_dummy(cmd))
                  state <= ST_DUMMY;
                else if (sfc_is_dio(cmd))
                  state <= ST_MODE;
                else
                  state <= ST_OUT;
              end
            end
            ST_MODE: begin
              state <= ST_OUT;
              cont  <= next_in[CONT_LSB +: 2] == CONT_KEY;
            end
            ST_DUMMY: state <= ST_OUT;
            ST_WDATA: begin
              wbuf_lo <= next_in;
              wbuf_hi <= wbuf_lo;
            end
            default: state <= state;
          endcase
        end
      end
    end
  end

  // ============================================================
  // status register and timed write cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stat    <= STAT_RST;
      wip_cyc <= 1'b0;
      tw_cnt  <= '0;
    end else begin
      if (wr_ok) begin
        stat    <= (stat & ~WR_MASK) | (wr_val & WR_MASK);
        wip_cyc <= 1'b1;
        tw_cnt  <= TCW'(TW_CYCLES - 1);
      end else if (cyc_end) begin
        wip_cyc       <= 1'b0;
        stat[WEL_BIT] <= 1'b0;
      end else if (wip_cyc) begin
        tw_cnt <= tw_cnt - 1'b1;
      end
      if (sw_reset || (exact0 && cmd == OP_WRDI && !busy))
        stat[WEL_BIT] <= 1'b0;
      if (exact0 && cmd == OP_WRITE_ENABLE_CMD)
        stat[WEL_BIT] <= 1'b1;
    end
  end

  // ============================================================
  // extended address register and reset arming
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ext       <= EXT_RST;
      rst_armed <= 1'b0;
    end else begin
      if (sw_reset)
        ext <= EXT_RST;
      else if (wr_frame && cmd == OP_WREXT && nbytes == 2'h1)
        ext <= wbuf_lo;
      if (cs_rise)
        rst_armed <= exact0 && cmd == OP_RSTEN;
    end
  end

  // ============================================================
  // fetch side and two-entry buffer
  logic [BUF_W-1:0] buf_mem [BUF_DEPTH];
  logic [AW-1:0]    wr_ptr, rd_ptr;
  logic [CW-1:0]    buf_cnt;
  logic             fetch_en, pend, drop, buf_full, buf_empty;
  logic             push, pop, req_hs, rsp_hs;
  assign buf_full      = buf_cnt == CW'(BUF_DEPTH);
  assign buf_empty     = buf_cnt == '0;
  assign mem_req_valid = fetch_en && !pend && !buf_full && !cs_rise;
  assign mem_rsp_ready = drop || !buf_full;
  assign req_hs        = mem_req_valid && mem_req_ready;
  assign rsp_hs        = mem_rsp_valid && mem_rsp_ready;
  assign push          = rsp_hs && !drop && !cs_rise;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(BUF_DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      fetch_en     <= 1'b0;
      mem_req_addr <= 32'h0;
      pend         <= 1'b0;
      drop         <= 1'b0;
    end else begin
      if (cs_rise)
        fetch_en <= 1'b0;
      else if (rd_go)
        fetch_en <= 1'b1;
      if (rd_go)
        mem_req_addr <= rd_base;
      else if (req_hs)
        mem_req_addr <= mem_req_addr + 32'h1;
      if (req_hs)
        pend <= 1'b1;
      else if (rsp_hs)
        pend <= 1'b0;
      if (cs_rise && pend && !rsp_hs)
        drop <= 1'b1;
      else if (rsp_hs)
        drop <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_ptr  <= '0;
      rd_ptr  <= '0;
      buf_cnt <= '0;
    end else if (cs_rise) begin
      wr_ptr  <= '0;
      rd_ptr  <= '0;
      buf_cnt <= '0;
    end else begin
      if (push)
        wr_ptr <= ptr_inc(wr_ptr);
      if (pop)
        rd_ptr <= ptr_inc(rd_ptr);
      if (push && !pop)
        buf_cnt <= buf_cnt + 1'b1;
      else if (pop && !push)
        buf_cnt <= buf_cnt - 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (push)
      buf_mem[wr_ptr] <= mem_rsp_data;
  end

  // ============================================================
  // output shifter, falling edges
  logic       tx;
  logic [3:0] w, out_cnt, lanes;
  logic [7:0] out_sh, src, next_sh;
  assign tx = sclk_fall && sel && state == ST_OUT;
  assign w  = sfc_width(cmd);
  assign pop = tx && out_cnt == '0 && sfc_is_read(cmd) && !buf_empty;

  always_comb begin
    case (cmd)
      OP_RDSR1: src = stat_view[7:0];
      OP_RDSR2: src = stat_view[15:8];
      OP_RDSR3: src = stat_view[23:16];
      OP_RDEXT: src = ext;
      default:  src = buf_empty ? FILL_BYTE : buf_mem[rd_ptr];
    endcase
    next_sh = (out_cnt == '0) ? src : 8'(out_sh << w);
    case (w)
      4'h2:    lanes = 4'h3;
      4'h4:    lanes = 4'hF;
      default: lanes = 4'h2;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      out_sh  <= 8'h00;
      out_cnt <= 4'h0;
      io_out  <= 4'h0;
      io_oe_n <= OE_OFF;
    end else begin
      if (cs_fall) begin
        out_cnt <= 4'h0;
      end else if (tx) begin
        out_sh  <= next_sh;
        out_cnt <= (out_cnt == '0) ? BYTE_BITS - w : out_cnt - w;
        case (w)
          4'h2:    io_out <= {2'h0, next_sh[7:6]};
          4'h4:    io_out <= next_sh[7:4];
          default: io_out <= {2'h0, next_sh[7], 1'b0};
        endcase
      end
      io_oe_n <= (state == ST_OUT && sel && !cs_rise) ? ~lanes : OE_OFF;
    end
  end

  assign status = '{status_protect: stat[SRP_BIT], protect_top_bottom: stat[TB_BIT],
                    block_protect: stat[BP_LSB +: 4], write_enable_latch: stat[WEL_BIT],
                    write_in_progress: busy};
  assign upper_address_bit = ext[0];
  assign continuous_mode   = cont;

  // ============================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_wr_go;
    wr_ok;
  endsequence
  sequence s_cyc_run;
    wip_cyc && status.write_in_progress;
  endsequence

  chk_write_enable_cmd_sets: assert property (
    exact0 && cmd == OP_WRITE_ENABLE_CMD |=> stat[WEL_BIT])
    else $error("write enable latch not set");
  chk_wip_start: assert property (
    s_wr_go |=> s_cyc_run ##1 s_cyc_run)
    else $error("write cycle did not start");
  chk_wel_end: assert property (
    cyc_end |=> !wip_cyc && !stat[WEL_BIT])
    else $error("write cycle end left flags set");
  chk_fixed_bits: assert property (
    wr_ok |=> stat_fixed == $past(stat_fixed))
    else $error("protected status bit changed");
  chk_no_latch: assert property (
    wr_frame && is_status_write_cmd && !stat[WEL_BIT] |=> !wip_cyc && stat == $past(stat))
    else $error("status write without latch");
  chk_hw_lock: assert property (
    wr_frame && is_status_write_cmd && hw_prot && !wip_cyc |=> !wip_cyc)
    else $error("status write under hardware protection");
  chk_ext_clear: assert property (
    sw_reset |=> ext == EXT_RST)
    else $error("extended register not cleared");
  chk_read_busy: assert property (
    rx && in_full && state == ST_OPC && sfc_is_read(next_in) && busy
    |=> state == ST_SKIP && !fetch_en)
    else $error("read accepted while busy");
  chk_cont_set: assert property (
    rx && in_full && state == ST_MODE && next_in[CONT_LSB +: 2] == CONT_KEY |=> cont)
    else $error("continuous mode not entered");
  chk_stat_repeat: assert property (
    tx && out_cnt == '0 && cmd == OP_RDSR1 |=> out_sh == $past(stat_view[7:0]))
    else $error("status byte not reloaded");
  chk_oe_drive: assert property (
    state == ST_OUT && sel && !cs_rise |=> io_oe_n != OE_OFF)
    else $error("data lines not driven");
endmodule
`default_nettype wire

// ### design/sfc_pkg.sv
// sfc_pkg: constants, types and helpers of the serial flash command front end
package sfc_pkg;
  // ============================================================
  // timing
  localparam int CLK_NS = 25;
  localparam int TW_NS  = 2000000; // status write cycle, plain default
  // ============================================================
  // opcodes
  localparam logic [7:0] OP_WRITE_ENABLE_CMD  = 8'h06;
  localparam logic [7:0] OP_WRDI  = 8'h04;
  localparam logic [7:0] OP_RDSR1 = 8'h05;
  localparam logic [7:0] OP_RDSR2 = 8'h35;
  localparam logic [7:0] OP_RDSR3 = 8'h15;
  localparam logic [7:0] OP_WRSR1 = 8'h01;
  localparam logic [7:0] OP_WRSR2 = 8'h31;
  localparam logic [7:0] OP_WRSR3 = 8'h11;
  localparam logic [7:0] OP_RDEXT = 8'hC8;
  localparam logic [7:0] OP_WREXT = 8'hC5;
  localparam logic [7:0] OP_READ  = 8'h03;
  localparam logic [7:0] OP_READ4 = 8'h13;
  localparam logic [7:0] OP_FAST  = 8'h0B;
  localparam logic [7:0] OP_FAST4 = 8'h0C;
  localparam logic [7:0] OP_DOUT  = 8'h3B;
  localparam logic [7:0] OP_DOUT4 = 8'h3C;
  localparam logic [7:0] OP_QOUT  = 8'h6B;
  localparam logic [7:0] OP_QOUT4 = 8'h6C;
  localparam logic [7:0] OP_DIO   = 8'hBB;
  localparam logic [7:0] OP_DIO4  = 8'hBC;
  localparam logic [7:0] OP_RSTEN = 8'h66;
  localparam logic [7:0] OP_RST   = 8'h99;
  // ============================================================
  // status layout and reset values
  localparam logic [23:0] WR_MASK  = 24'hF37AFC;
  localparam logic [23:0] STAT_RST = 24'h000000;
  localparam int WIP_BIT = 0;
  localparam int WEL_BIT = 1;
  localparam int BP_LSB  = 2;
  localparam int TB_BIT  = 6;
  localparam int SRP_BIT = 7;
  localparam int CONT_LSB = 4;
  localparam logic [1:0] CONT_KEY = 2'h2;
  localparam logic [7:0] EXT_RST   = 8'h00;
  localparam logic [7:0] FILL_BYTE = 8'hFF;
  localparam logic [3:0] OE_OFF    = 4'hF;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [2:0] ALEN3     = 3'h3;
  localparam logic [2:0] ALEN4     = 3'h4;
  localparam logic [1:0] NB_MAX    = 2'h3;
  // ============================================================
  // types
  typedef enum logic [2:0] {
    ST_OPC, ST_ADDR, ST_MODE, ST_DUMMY, ST_OUT, ST_WDATA, ST_SKIP
  } sfc_state_e;
  typedef struct packed {
    logic       wp_n;
    logic [3:0] io;
    logic       cs_n;
    logic       sclk;
  } sfc_pins_s;
  typedef struct packed {
    logic       status_protect;
    logic       protect_top_bottom;
    logic [3:0] block_protect;
    logic       write_enable_latch;
    logic       write_in_progress;
  } sfc_status_s;
  localparam sfc_pins_s PINS_RST = '{wp_n: 1'b1, io: 4'h0, cs_n: 1'b1, sclk: 1'b0};
  // ============================================================
  // opcode decoding
  function automatic logic sfc_is_read(input logic [7:0] op);
    case (op)
      OP_READ, OP_READ4, OP_FAST, OP_FAST4, OP_DOUT, OP_DOUT4,
      OP_QOUT, OP_QOUT4, OP_DIO, OP_DIO4: sfc_is_read = 1'b1;
      default: sfc_is_read = 1'b0;
    endcase
  endfunction
  function automatic logic sfc_is_4b(input logic [7:0] op);
    case (op)
      OP_READ4, OP_FAST4, OP_DOUT4, OP_QOUT4, OP_DIO4: sfc_is_4b = 1'b1;
      default: sfc_is_4b = 1'b0;
    endcase
  endfunction
  function automatic logic sfc_is_dio(input logic [7:0] op);
    sfc_is_dio = (op == OP_DIO) || (op == OP_DIO4);
  endfunction
  function automatic logic sfc_has_dummy(input logic [7:0] op);
    sfc_has_dummy = sfc_is_read(op) && !sfc_is_dio(op) && op != OP_READ && op != OP_READ4;
  endfunction
  // data lines per clock in the output phase
  function automatic logic [3:0] sfc_width(input logic [7:0] op);
    case (op)
      OP_DOUT, OP_DOUT4, OP_DIO, OP_DIO4: sfc_width = 4'h2;
      OP_QOUT, OP_QOUT4: sfc_width = 4'h4;
      default: sfc_width = 4'h1;
    endcase
  endfunction
endpackage

// ### bench/sfc_host_model.sv
// sfc_host_model: host side of the serial link
`timescale 1ns/1ps
`default_nettype none
module sfc_host_model
  import sfc_pkg::*;
(
  input  wire logic                  clock,   // system clock
  input  wire logic [3:0]            io_out,  // device line values
  input  wire logic [3:0]            io_oe_n, // device enables
  output var  sfc_pkg::sfc_pins_s    pins     // link pins
);
  logic link_cs_n = 1'b1;
  logic link_sclk = 1'b0;
  logic host_io   = 1'b0;
  // undriven lines pulled up
  assign pins = '{wp_n: 1'b1, io: (io_out & ~io_oe_n) | ({3'h7, host_io} & io_oe_n),
                  cs_n: link_cs_n, sclk: link_sclk};
  task automatic frame_start();
    @(posedge clock) link_cs_n <= 1'b0;
    repeat (4) @(posedge clock);
  endtask
  // one byte, msb first, 200 ns per bit; sampled late in the high phase
  task automatic xfer(input logic [7:0] o, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      host_io <= o[i];
      link_sclk <= 1'b0;
      repeat (4) @(posedge clock);
      link_sclk <= 1'b1;
      repeat (4) @(posedge clock);
      r[i] = pins.io[1];
    end
  endtask
  task automatic frame_end();
    link_sclk <= 1'b0;
    repeat (4) @(posedge clock);
    link_cs_n <= 1'b1;
    repeat (8) @(posedge clock);
  endtask
endmodule
`default_nettype wire

// ### bench/test_serial_flash_status_and_read_cmds.sv
// test_serial_flash_status_and_read_cmds: self-checking bench of the front end
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_mismatch++; \
  $display("ERROR %0t got %h exp %h", $time, (a), (e)); end end
module test_serial_flash_status_and_read_cmds;
  import sfc_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic mem_rsp_valid = 1'b0;
  logic [7:0] mem_rsp_data = 8'h00;
  logic mem_req_valid, mem_rsp_ready, upper_bit, cont_mode;
  logic four_b = 1'b0;
  logic arr_busy = 1'b0;
  logic [31:0] mem_req_addr;
  logic [3:0] io_out, io_oe_n;
  sfc_pins_s pins;
  sfc_status_s status;
  int n_mismatch = 0;
  int n_tests = 0;
  int cyc = 0;
  initial begin
    forever #12.5 clock = ~clock;
  end
  sfc_flash_front #(.TW_CYCLES(200)) sfc_flash_front_inst (.clock(clock), .rst(rst),
    .pins(pins), .io_out(io_out), .io_oe_n(io_oe_n), .addr_four_byte_state(four_b),
    .array_busy(arr_busy), .mem_req_valid(mem_req_valid), .mem_req_ready(1'b1),
    .mem_req_addr(mem_req_addr), .mem_rsp_valid(mem_rsp_valid),
    .mem_rsp_ready(mem_rsp_ready), .mem_rsp_data(mem_rsp_data), .status(status),
    .upper_address_bit(upper_bit), .continuous_mode(cont_mode));
  sfc_host_model sfc_host_model_inst (.clock(clock), .io_out(io_out), .io_oe_n(io_oe_n),
    .pins(pins));
  function automatic logic [7:0] mem_byte(input logic [31:0] a);
    return a[7:0] ^ {7'h00, a[24]} ^ 8'h3C;
  endfunction
  // ==========================================================
  // memory responder
  always @(posedge clock) begin
    if (mem_req_valid) begin
      mem_rsp_valid <= 1'b1;
      mem_rsp_data <= mem_byte(mem_req_addr);
    end else if (mem_rsp_ready) begin
      mem_rsp_valid <= 1'b0;
    end
  end
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      complete_run();
    end
  end
  // one frame: opcode, then n bytes out; last byte returned
  task automatic frame(input logic [7:0] op, input logic [31:0] v, input int n,
                       output logic [7:0] r);
    sfc_host_model_inst.frame_start();
    sfc_host_model_inst.xfer(op, r);
    for (int i = n - 1; i >= 0; i--) sfc_host_model_inst.xfer(v[8*i +: 8], r);
    sfc_host_model_inst.frame_end();
  endtask
  // ==========================================================
  // main sequence
  initial begin
    logic [7:0] r, d, e;
    logic [23:0] a;
    int busy;
    void'($urandom(83));
    d = 8'($urandom());
    e = 8'($urandom()) | 8'h01;
    a = 24'($urandom());
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    repeat (8) @(posedge clock);
    frame(OP_RDEXT, 0, 1, r);
    `CHK(r, 8'h00)
    frame(OP_WRITE_ENABLE_CMD, 0, 0, r);
    `CHK(status.write_enable_latch, 1'b1)
    frame(OP_WRSR1, {24'h0, d}, 1, r);
    `CHK(status.write_in_progress, 1'b1)
    sfc_host_model_inst.frame_start();
    sfc_host_model_inst.xfer(OP_RDSR1, r);
    busy = 0;
    for (int i = 0; i < 20; i++) begin
      sfc_host_model_inst.xfer(8'h00, r);
      if (r[WIP_BIT] !== 1'b1) break;
      busy++;
    end
    sfc_host_model_inst.frame_end();
    `CHK(busy > 0, 1'b1)
    `CHK(r, d & WR_MASK[7:0])
    `CHK(status.block_protect, d[5:2])
    `CHK(status.write_enable_latch, 1'b0)
    frame(OP_RDSR2, 0, 1, r);
    `CHK(r, 8'h00)
    $display("done status write");
    frame(OP_WRSR1, {24'h0, ~d}, 1, r);
    repeat (250) @(posedge clock);
    frame(OP_RDSR1, 0, 1, r);
    `CHK(r, d & WR_MASK[7:0])
    $display("done refused write");
    frame(OP_WREXT, {24'h0, e}, 1, r);
    frame(OP_RDEXT, 0, 1, r);
    `CHK(r, e)
    `CHK(upper_bit, e[0])
    $display("done extended register");
    for (int m = 0; m < 2; m++) begin
      four_b <= m[0];
      sfc_host_model_inst.frame_start();
      sfc_host_model_inst.xfer(OP_READ, r);
      for (int i = 2 + m; i >= 0; i--)
        sfc_host_model_inst.xfer(8'({8'h00, a} >> (8 * i)), r);
      for (int i = 0; i < 3; i++) begin
        sfc_host_model_inst.xfer(8'h00, r);
        `CHK(r, mem_byte((m ? {8'h00, a} : {7'h00, e[0], a}) + i))
        `CHK(io_oe_n, 4'hD)
      end
      sfc_host_model_inst.frame_end();
    end
    `CHK(cont_mode, 1'b0)
    $display("done plain read");
    arr_busy <= 1'b1;
    frame(OP_READ, {8'h00, a}, 4, r);
    `CHK(r, 8'hFF)
    `CHK(status.write_in_progress, 1'b1)
    arr_busy <= 1'b0;
    $display("done busy read");
    complete_run();
  end
endmodule
`default_nettype wire
